// ===== logic/cra_map.svh
// clock rate adapter: register offsets, field positions, reset values
// and timing counts, shared by the package user and the design files
`ifndef CRA_MAP_SVH
`define CRA_MAP_SVH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define CRA_REG_CTRL 4'h0
`define CRA_REG_SEL 4'h4
`define CRA_REG_STAT 4'h8

// control register bits
`define CRA_CTRL_EN 0
`define CRA_CTRL_DJ_EN 1
`define CRA_CTRL_FREE 2
`define CRA_CTRL_PIN_OE 3
`define CRA_CTRL_SB_OE 4
`define CRA_CTRL_E1 5
`define CRA_CTRL_RESET 6'h00

// selection register fields
`define CRA_SEL_OSEL_LSB 0
`define CRA_SEL_SRC_LSB 4
`define CRA_SEL_XSEL_LSB 8
`define CRA_SEL_RESET 14'h0000

// status register bits
`define CRA_STAT_LOCK 0
`define CRA_STAT_PWR 1
`define CRA_STAT_FREE 2

// ----------------------------------------------------------------------
// frequencies and counts
// ----------------------------------------------------------------------
`define CRA_REF_KHZ 32'd10000
`define CRA_T1_KHZ 32'd1544
`define CRA_E1_KHZ 32'd2048
`define CRA_EXT_BASE_KHZ 32'd8
`define CRA_OUT_COUNT 14
`define CRA_EXT_COUNT 6'd44
`define CRA_OUT_KHZ '{32'd8, 32'd16, 32'd32, 32'd56, 32'd64, 32'd128, \
  32'd256, 32'd512, 32'd1024, 32'd1536, 32'd1544, 32'd2048, 32'd3088, \
  32'd4096}
`define CRA_PWRUP_REF_CYCLES 12'd3000
`define CRA_LOCK_TOL 24'sd32768
`define CRA_LOCK_HOLD 16'h0400
`define CRA_PERR_MAX 24'sh3f_ffff

`endif

// ===== logic/cra_pkg.sv
// clock rate adapter types: loop states and the register state record
// assumes cra_map.svh is not needed here; only types live in this file
`default_nettype none

package cra_pkg;

  // ----------------------------------------------------------------------
  // loop state, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CRA_FREE = 3'b001,
    CRA_ACQ = 3'b010,
    CRA_LOCK = 3'b100
  } cra_loop_t;

  // ----------------------------------------------------------------------
  // whole state of the adapter core
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic en;                   // adapter enable
    logic dj_en;                // dejitter enable
    logic free_run;             // oscillator free run
    logic pin_oe;               // pin output enable
    logic sb_oe;                // system bus output enable
    logic e1;                   // line rate is e1
    logic [3:0] osel;           // output frequency select
    logic [1:0] src;            // reference source
    logic [5:0] xsel;           // external reference frequency index
    logic [3:0] osel_prev;
    logic [1:0] src_prev;
    logic [5:0] xsel_prev;
    cra_loop_t loop;
    logic [31:0] acc;           // output oscillator phase
    logic [31:0] dj_acc;        // dejitter oscillator phase
    logic signed [23:0] perr;   // phase error in khz-cycles
    logic [15:0] hold;          // lock qualification count
    logic [11:0] pwr_cnt;       // reference edges since reset
    logic pwr_done;
    logic clk_out;
    logic dj_clk;
    logic ack;
    logic [31:0] rdata;
    logic [3:0] lvl_prev;       // previous synchronised levels
  } cra_state_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] lvl;
  } cra_sync_t;

endpackage
`default_nettype wire

// ===== logic/cra_pin_sync.sv
// three-stage pin synchroniser with agreement filter, one per bit
// assumes inputs are asynchronous to core_clk_i
`timescale 1ns/1ps
`default_nettype none

module cra_pin_sync
  import cra_pkg::*;
#(
  parameter int W = 4
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // pins and clean levels
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  // the state record is four bits wide per stage
  if (W < 1 || W > 4) begin : g_bad_w
    $error("cra_pin_sync: W must be 1 to 4");
  end

  cra_sync_t st;
  cra_sync_t next_st;

  // ----------------------------------------------------------------------
  // next state: shift in, accept a change once stages two and three agree
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.s1 = '0;
    next_st.s1[W-1:0] = pin_i;
    next_st.s2 = st.s1;         // stage one feeds stage two only
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.lvl[i] = st.s3[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.lvl[W-1:0];

endmodule
`default_nettype wire

// ===== logic/cra_adapter.sv
// clock rate adapter core: oscillator, phase loop, power-up hold and
// avalon-mm register slave
// assumes osc_ref_clk_i toggles at 10 MHz and stays below half of
// core_clk_i; the link clocks are sampled as ordinary pins
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cra_map.svh"

module cra_adapter
  import cra_pkg::*;
#(
  parameter bit HAS_CLK_OUT = 1'b1,  // variant with synthesized output
  parameter int KP = 4                 // loop gain as a right shift
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // timing pins
  input wire logic osc_ref_clk_i,
  input wire logic rx_line_clk_i,
  input wire logic tx_clk_i,
  input wire logic adapter_ref_in_i,
  // synthesized clocks
  output logic adapter_clk_out_o,
  output logic adapter_clk_out_oe_n_o,
  output logic dejitter_clk_o,
  // output enables for the rest of the chip
  output logic pin_oe_n_o,
  output logic sysbus_oe_n_o,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  if (KP < 1 || KP > 16) begin : g_bad_kp
    $error("cra_adapter: KP must be 1 to 16");
  end

  typedef logic [31:0] cra_tab_t [`CRA_OUT_COUNT];

  // ----------------------------------------------------------------------
  // increments per reference edge, fixed at elaboration
  // ----------------------------------------------------------------------
  function automatic logic [31:0] inc_of(input logic [31:0] khz);
    logic [63:0] wide;
    wide = {khz, 32'h0000_0000} / {32'h0000_0000, `CRA_REF_KHZ};
    return wide[31:0];
  endfunction

  function automatic cra_tab_t inc_table();
    cra_tab_t khz;
    cra_tab_t t;
    khz = `CRA_OUT_KHZ;
    for (int i = 0; i < `CRA_OUT_COUNT; i++) begin
      t[i] = inc_of(khz[i]);
    end
    return t;
  endfunction

  localparam cra_tab_t OUT_KHZ = `CRA_OUT_KHZ;
  localparam cra_tab_t OUT_INC = inc_table();
  localparam logic [31:0] T1_INC = inc_of(`CRA_T1_KHZ);
  localparam logic [31:0] E1_INC = inc_of(`CRA_E1_KHZ);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] lvl;              // ref, rx, tx, external

  cra_pin_sync #(
    .W(4)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .pin_i({adapter_ref_in_i, tx_clk_i, rx_line_clk_i, osc_ref_clk_i}),
    .level_o(lvl)
  );

  cra_state_t st;
  cra_state_t next_st;

  // combinational helpers
  logic [3:0] rise;             // rising edges of the clean levels
  logic ref_edge;               // edge of the selected reference
  logic [31:0] ref_khz;         // frequency of the selected reference
  logic [31:0] out_khz;
  logic [31:0] ext_base;
  logic [31:0] inc;
  logic [32:0] acc_sum;
  logic [32:0] dj_sum;
  logic locking;
  logic changed;
  logic signed [25:0] err_sum;
  logic [31:0] corr;
  logic hit;
  logic [3:0] be_osel;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    rise = lvl & ~st.lvl_prev;
    next_st.lvl_prev = lvl;
    out_khz = OUT_KHZ[st.osel];

    // external reference: 8 kHz times a power of two times 1, 5/4, 3/2, 2
    ext_base = `CRA_EXT_BASE_KHZ << st.xsel[5:2];
    unique case (st.xsel[1:0])
      2'd0: ref_khz = ext_base;
      2'd1: ref_khz = ext_base + (ext_base >> 2);
      2'd2: ref_khz = ext_base + (ext_base >> 1);
      default: ref_khz = ext_base << 1;
    endcase

    // reference source: 0 none, 1 receive line, 2 transmit, 3 external
    unique case (st.src)
      2'd1: begin
        ref_edge = rise[1];
        ref_khz = st.e1 ? `CRA_E1_KHZ : `CRA_T1_KHZ;
      end
      2'd2: begin
        ref_edge = rise[2];
        ref_khz = st.e1 ? `CRA_E1_KHZ : `CRA_T1_KHZ;
      end
      2'd3: ref_edge = rise[3];
      default: ref_edge = 1'b0;
    endcase

    // closed loop only with both enables and no free run
    locking = st.en && st.dj_en && !st.free_run && (st.src != 2'd0);
    changed = (st.osel != st.osel_prev) || (st.src != st.src_prev) ||
              (st.xsel != st.xsel_prev);
    next_st.osel_prev = st.osel;
    next_st.src_prev = st.src;
    next_st.xsel_prev = st.xsel;

    // proportional trim on phase error; zero when free running
    corr = locking ? 32'(st.perr >>> KP) : 32'h0000_0000;
    inc = OUT_INC[st.osel] + corr;

    // oscillators advance only on reference clock edges
    acc_sum = {1'b0, st.acc} + {1'b0, inc};
    dj_sum = {1'b0, st.dj_acc} + {1'b0, (st.e1 ? E1_INC : T1_INC) + corr};
    if (rise[0]) begin
      next_st.acc = acc_sum[31:0];
      next_st.dj_acc = dj_sum[31:0];
    end

    // phase error: gains output rate per reference edge, loses reference
    // rate per output cycle, so it settles when the ratio is right
    err_sum = 26'(st.perr) + (ref_edge ? 26'(out_khz) : 26'sd0) -
              ((rise[0] && acc_sum[32]) ? 26'(ref_khz) : 26'sd0);
    if (err_sum > 26'(`CRA_PERR_MAX)) begin
      next_st.perr = `CRA_PERR_MAX;
    end else if (err_sum < -26'(`CRA_PERR_MAX)) begin
      next_st.perr = -`CRA_PERR_MAX;
    end else begin
      next_st.perr = err_sum[23:0];
    end
    hit = (st.perr < `CRA_LOCK_TOL) && (st.perr > -`CRA_LOCK_TOL);

    // loop state machine
    unique case (st.loop)
      CRA_FREE: begin
        next_st.perr = '0;
        next_st.hold = '0;
        if (locking) begin
          next_st.loop = CRA_ACQ;
        end
      end
      CRA_ACQ: begin
        next_st.hold = hit ? st.hold + 16'h0001 : 16'h0000;
        if (st.hold == `CRA_LOCK_HOLD) begin
          next_st.loop = CRA_LOCK;
        end
      end
      CRA_LOCK: begin
        // a large excursion means the reference moved; start over
        if (!hit) begin
          next_st.loop = CRA_ACQ;
          next_st.hold = '0;
        end
      end
    endcase
    if (!locking) begin
      next_st.loop = CRA_FREE;
    end else if (changed) begin
      next_st.loop = CRA_ACQ;
      next_st.perr = '0;
      next_st.hold = '0;
    end

    // power-up: pins stay released until enough reference edges passed
    if (rise[0] && !st.pwr_done) begin
      next_st.pwr_cnt = st.pwr_cnt + 12'h001;
      if (st.pwr_cnt == `CRA_PWRUP_REF_CYCLES - 12'h001) begin
        next_st.pwr_done = 1'b1;
      end
    end

    // registered clock outputs; the reduced variant drives low
    next_st.clk_out = HAS_CLK_OUT && st.en && st.acc[31];
    next_st.dj_clk = st.dj_en && st.dj_acc[31];

    // bus slave: answer one cycle after the request is seen
    next_st.ack = (avs_read || avs_write) && !st.ack;
    next_st.rdata = '0;
    if (avs_read && !st.ack) begin
      unique case (avs_address)
        `CRA_REG_CTRL: begin
          next_st.rdata[`CRA_CTRL_EN] = st.en;
          next_st.rdata[`CRA_CTRL_DJ_EN] = st.dj_en;
          next_st.rdata[`CRA_CTRL_FREE] = st.free_run;
          next_st.rdata[`CRA_CTRL_PIN_OE] = st.pin_oe;
          next_st.rdata[`CRA_CTRL_SB_OE] = st.sb_oe;
          next_st.rdata[`CRA_CTRL_E1] = st.e1;
        end
        `CRA_REG_SEL: begin
          next_st.rdata[`CRA_SEL_OSEL_LSB +: 4] = st.osel;
          next_st.rdata[`CRA_SEL_SRC_LSB +: 2] = st.src;
          next_st.rdata[`CRA_SEL_XSEL_LSB +: 6] = st.xsel;
        end
        `CRA_REG_STAT: begin
          next_st.rdata[`CRA_STAT_LOCK] = (st.loop == CRA_LOCK);
          next_st.rdata[`CRA_STAT_PWR] = st.pwr_done;
          next_st.rdata[`CRA_STAT_FREE] = (st.loop == CRA_FREE);
        end
        default: next_st.rdata = '0;  // unmapped reads return zero
      endcase
    end
    be_osel = avs_writedata[`CRA_SEL_OSEL_LSB +: 4];
    if (avs_write && st.ack) begin
      if (avs_address == `CRA_REG_CTRL && avs_byteenable[0]) begin
        next_st.en = avs_writedata[`CRA_CTRL_EN];
        next_st.dj_en = avs_writedata[`CRA_CTRL_DJ_EN];
        next_st.free_run = avs_writedata[`CRA_CTRL_FREE];
        next_st.pin_oe = avs_writedata[`CRA_CTRL_PIN_OE];
        next_st.sb_oe = avs_writedata[`CRA_CTRL_SB_OE];
        next_st.e1 = avs_writedata[`CRA_CTRL_E1];
      end
      if (avs_address == `CRA_REG_SEL && avs_byteenable[0]) begin
        // out-of-range codes are ignored, the old choice stays
        if (be_osel < 4'(`CRA_OUT_COUNT)) begin
          next_st.osel = be_osel;
        end
        next_st.src = avs_writedata[`CRA_SEL_SRC_LSB +: 2];
      end
      if (avs_address == `CRA_REG_SEL && avs_byteenable[1] &&
          avs_writedata[`CRA_SEL_XSEL_LSB +: 6] < `CRA_EXT_COUNT) begin
        next_st.xsel = avs_writedata[`CRA_SEL_XSEL_LSB +: 6];
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st <= '0;
      st.loop <= CRA_FREE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // pins float from reset until power-up count and enable both allow
  assign adapter_clk_out_o = st.clk_out;
  assign adapter_clk_out_oe_n_o = !(st.pwr_done && st.pin_oe);
  assign dejitter_clk_o = st.dj_clk;
  assign pin_oe_n_o = !(st.pwr_done && st.pin_oe);
  assign sysbus_oe_n_o = !(st.pwr_done && st.sb_oe);
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !st.ack;

endmodule
`default_nettype wire

// ===== dv/cra_adapter_properties.sv
// checker: bus timing, output enables and clock gating
// assumes it is bound to every cra_adapter; sees ports only
`timescale 1ns/1ps
`default_nettype none

module cra_adapter_checker #(
  parameter bit HAS_CLK_OUT = 1'b1
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // pins
  input wire logic osc_ref_clk_i,
  input wire logic adapter_clk_out_o,
  input wire logic adapter_clk_out_oe_n_o,
  input wire logic dejitter_clk_o,
  input wire logic pin_oe_n_o,
  input wire logic sysbus_oe_n_o,
  // avalon-mm
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // ----------------------------------------------------------
  // helper state
  // ----------------------------------------------------------
  logic [4:0] ctl; // control bits from completed writes
  logic ref_q; // last sampled reference level
  logic [11:0] ref_cnt; // raw edges, never behind the synced ones
  logic req; // any request
  assign req = avs_read | avs_write;

  // count saturates so a long run never wraps below the limit
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctl <= 5'h00;
      ref_q <= 1'b0;
      ref_cnt <= 12'h000;
    end else begin
      ref_q <= osc_ref_clk_i;
      if (osc_ref_clk_i && !ref_q && ref_cnt != 12'hfff) begin
        ref_cnt <= ref_cnt + 12'h001;
      end
      if (avs_write && !avs_waitrequest && avs_address == 4'h0 &&
          avs_byteenable[0]) begin
        ctl <= avs_writedata[4:0];
      end
    end
  end

  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  AST_WAIT_BEGIN: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("waitrequest low at request start");
  AST_WAIT_ONE: assert property (req && avs_waitrequest |=>
    !req || !avs_waitrequest) else $error("no answer after one cycle");
  AST_RDATA_IDLE: assert property (!(avs_read && !avs_waitrequest) |->
    avs_readdata == 32'h0000_0000) else $error("readdata outside answer");
  AST_OE_PWRUP: assert property (ref_cnt < 12'hbb8 |->
    pin_oe_n_o && sysbus_oe_n_o && adapter_clk_out_oe_n_o)
    else $error("output driven before power-up");
  AST_PIN_OE: assert property (!pin_oe_n_o || !sysbus_oe_n_o |->
    (pin_oe_n_o || ctl[3] || $past(ctl[3])) &&
    (sysbus_oe_n_o || ctl[4] || $past(ctl[4])))
    else $error("output driven without enable");
  AST_CLK_OFF: assert property (!ctl[0] && !$past(ctl[0]) &&
    !$past(ctl[0], 2) |-> !adapter_clk_out_o)
    else $error("output clock runs while disabled");
  AST_DJ_OFF: assert property (!ctl[1] && !$past(ctl[1]) &&
    !$past(ctl[1], 2) |-> !dejitter_clk_o)
    else $error("dejitter clock runs while disabled");
  AST_VARIANT_LOW: assert property (!HAS_CLK_OUT |->
    !adapter_clk_out_o) else $error("variant output not low");
endmodule

bind cra_adapter cra_adapter_checker #(.HAS_CLK_OUT(HAS_CLK_OUT)) u_chk (
  .core_clk_i, .reset_i, .osc_ref_clk_i, .adapter_clk_out_o,
  .adapter_clk_out_oe_n_o, .dejitter_clk_o, .pin_oe_n_o, .sysbus_oe_n_o,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest);
`default_nettype wire

// ===== dv/cra_timing_model.sv
// timing sources beside the adapter: reference, line clocks, external
// assumes nothing; all run free and unrelated to the core clock
`timescale 1ns/1ps
`default_nettype none

module cra_timing_model #(
  parameter real EXT_HALF_NS = 3906.25 // 128 khz, index 16
) (
  // clocks toward the adapter
  output logic osc_ref_clk_o,
  output logic rx_line_clk_o,
  output logic tx_clk_o,
  output logic adapter_ref_in_o
);
  // never stopped: the oscillator has no other base
  initial begin
    osc_ref_clk_o = 1'b0;
    forever #50.0 osc_ref_clk_o = ~osc_ref_clk_o;
  end
  // t1 receive line clock
  initial begin
    rx_line_clk_o = 1'b1;
    forever #323.834 rx_line_clk_o = ~rx_line_clk_o;
  end
  // e1 transmit clock
  initial begin
    tx_clk_o = 1'b0;
    forever #244.141 tx_clk_o = ~tx_clk_o;
  end
  // optional external reference
  initial begin
    adapter_ref_in_o = 1'b1;
    forever #(EXT_HALF_NS) adapter_ref_in_o = ~adapter_ref_in_o;
  end
endmodule
`default_nettype wire

// ===== dv/cra_testbench.sv
// bench for the clock rate adapter: registers, power-up hold, rates
// assumes package, map header, design and checker compiled first
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  logic core_clk_i, reset_i;
  logic osc_ref_clk_i, rx_line_clk_i, tx_clk_i, adapter_ref_in_i;
  logic adapter_clk_out_o, adapter_clk_out_oe_n_o, dejitter_clk_o;
  logic pin_oe_n_o, sysbus_oe_n_o, var_clk;
  logic [3:0] avs_address, avs_byteenable, osel;
  logic avs_read, avs_write, avs_waitrequest, e1;
  logic [31:0] avs_writedata, avs_readdata, q;
  int mismatches, n_checks, na, nd, nv;
  integer seed; // $random wants a 32-bit integer variable
  int khz_tab [14] = '{8, 16, 32, 56, 64, 128, 256, 512, 1024, 1536,
    1544, 2048, 3088, 4096}; // output rates by select index

  cra_timing_model u_src (.osc_ref_clk_o(osc_ref_clk_i),
    .rx_line_clk_o(rx_line_clk_i), .tx_clk_o(tx_clk_i),
    .adapter_ref_in_o(adapter_ref_in_i));
  cra_adapter u_dut (.*);
  // variant without a synthesized output; only its clock pin is watched
  cra_adapter #(.HAS_CLK_OUT(1'b0)) u_var (.*, .adapter_clk_out_o(var_clk),
    .adapter_clk_out_oe_n_o(), .dejitter_clk_o(), .pin_oe_n_o(),
    .sysbus_oe_n_o(), .avs_readdata(), .avs_waitrequest());

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // edges of a khz clock in a 100 us window, rounded
  function automatic int exp_edges(input int khz);
    return (khz + 5) / 10;
  endfunction
  function automatic logic [31:0] near(input int g, e, tol);
    return {31'h0, (g >= e - tol) && (g <= e + tol)};
  endfunction
  // case equality, so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one avalon-mm access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // the slave answers one cycle after the request, at the second edge
    chk(n, 32'd2);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // rising edges of both clocks and the variant over 4000 cycles
  task automatic measure();
    logic pa, pd, pv;
    na = 0;
    nd = 0;
    nv = 0;
    pa = adapter_clk_out_o;
    pd = dejitter_clk_o;
    pv = var_clk;
    repeat (4000) begin
      @(posedge core_clk_i);
      if (adapter_clk_out_o && !pa) na++;
      if (dejitter_clk_o && !pd) nd++;
      if (var_clk && !pv) nv++;
      pa = adapter_clk_out_o;
      pd = dejitter_clk_o;
      pv = var_clk;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    seed = 32'ha24e_2c2a;
    reset_i = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (8) @(posedge core_clk_i);
    reset_i <= 1'b0;
    chk({29'h0, adapter_clk_out_oe_n_o, pin_oe_n_o, sysbus_oe_n_o}, 32'h7);
    rd_chk(4'h0, 32'h0);
    rd_chk(4'h8, 32'h4);
    rd_chk(4'hc, 32'h0);
    bus(1'b1, 4'h8, 32'hffff_ffff);
    rd_chk(4'h8, 32'h4);
    // enables set early must not release the pins
    bus(1'b1, 4'h0, 32'h1f);
    chk({30'h0, pin_oe_n_o, sysbus_oe_n_o}, 32'h3);
    repeat (12200) @(posedge core_clk_i);
    chk({29'h0, adapter_clk_out_oe_n_o, pin_oe_n_o, sysbus_oe_n_o}, 32'h0);
    rd_chk(4'h8, 32'h6);
    // free-running rates: both ends of the table, then random
    for (int i = 0; i < 8; i++) begin
      osel = (i == 0) ? 4'hd : (i == 1) ? 4'h0 :
        4'($unsigned($random(seed)) % 14);
      e1 = 1'($random(seed));
      bus(1'b1, 4'h0, {26'h0, e1, 5'h1f});
      bus(1'b1, 4'h4, {28'h0, osel});
      rd_chk(4'h4, {28'h0, osel});
      measure();
      chk(near(na, exp_edges(khz_tab[osel]), 2), 32'h1);
      chk(near(nd, exp_edges(e1 ? 2048 : 1544), 2), 32'h1);
      chk(near(nv, 0, 0), 32'h1);
    end
    // select 14 and index 44 refused; source still taken
    bus(1'b1, 4'h4, 32'h0000_2c3e);
    rd_chk(4'h4, {24'h0, 4'h3, osel});
    // closed loop on the external reference, then a fresh selection
    bus(1'b1, 4'h0, 32'h1b);
    bus(1'b1, 4'h4, 32'h0000_103b);
    rd_chk(4'h8, 32'h2);
    measure();
    chk(near(na, exp_edges(2048), 41), 32'h1);
    rd_chk(4'h8, 32'h3);
    // a new output rate must drop the lock and start over
    bus(1'b1, 4'h4, 32'h0000_103a);
    rd_chk(4'h8, 32'h2);
    // clearing the enables stops both clocks and frees the pins
    bus(1'b1, 4'h0, 32'h0);
    // the output register still carries one edge launched while enabled
    repeat (2) @(posedge core_clk_i);
    measure();
    chk(near(na + nd, 0, 0), 32'h1);
    chk({30'h0, pin_oe_n_o, sysbus_oe_n_o}, 32'h3);
    // a second reset must return the pins to high impedance
    bus(1'b1, 4'h0, 32'h18);
    repeat (2) @(posedge core_clk_i);
    chk({30'h0, pin_oe_n_o, sysbus_oe_n_o}, 32'h0);
    reset_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    chk({30'h0, pin_oe_n_o, sysbus_oe_n_o}, 32'h3);
    rd_chk(4'h0, 32'h0);
    report_and_stop();
  end

  // hang guard, about 52000 cycles expected
  initial begin
    repeat (90000) @(posedge core_clk_i);
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
